/* File: inc/scs_pkg.sv */
// shared constants and types for the synchronous sram control front end
// assumes: one clock, controller logic on the same clock as the device
package scs_pkg;

  // storage geometry defaults
  localparam int SCS_ADDR_W  = 8;            // full word address width, low two are burst bits
  localparam int SCS_LANES   = 4;            // byte lanes a..d
  localparam int SCS_LANE_W  = 9;            // eight data bits plus one parity_lane bit
  localparam int SCS_BURST_W = 2;            // two-bit burst counter
  localparam int SCS_DATA_W  = SCS_LANES * SCS_LANE_W;

  // burst order strap encoding: ground selects linear, high or open selects interleaved
  localparam logic SCS_MODE_LINEAR      = 1'h0;
  localparam logic SCS_MODE_RST         = 1'h1;  // open pin reads as interleaved
  localparam logic SCS_OE_N_RST         = 1'h1;
  localparam logic SCS_DRIVE_OFF_N      = 1'h1;  // enable low means the device drives

  // reset values of pipeline state, plus the burst counter step
  localparam logic [SCS_BURST_W-1:0] SCS_BURST_RST = 2'h0;
  localparam logic [SCS_BURST_W-1:0] SCS_BEAT_STEP = 2'h1;
  localparam logic [SCS_LANES-1:0]   SCS_LANES_OFF = 4'hF;

  // operation held for the beat whose address was captured last
  typedef enum logic [1:0] {
    SCS_OP_IDLE  = 2'b00,
    SCS_OP_READ  = 2'b01,
    SCS_OP_WRITE = 2'b10
  } scs_op_e;

  // one beat as captured on a qualified edge
  typedef struct packed {
    scs_op_e                  op;
    logic [SCS_ADDR_W-1:0]    addr;
    logic [SCS_LANES-1:0]     lane_n;
  } scs_beat_s;

  // strap and asynchronous pin levels that pass the three-flop filter
  typedef struct packed {
    logic out_en_n;
    logic burst_mode;
  } scs_pins_s;

endpackage

/* File: rtl/scs_burst_ctr.sv */
// two-bit burst counter: seeds from the low address bits, steps per beat
// assumes: load and advance are already qualified by the clock gate
`timescale 1ns/1ps
module scs_burst_ctr
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // control
  input  wire logic                   load,
  input  wire logic                   advance,
  input  wire logic                   linear,
  input  wire logic [SCS_BURST_W-1:0] seed,
  // low address bits for the beat being started
  output logic      [SCS_BURST_W-1:0] burst_low
);

  logic [SCS_BURST_W-1:0] seed_ff;
  logic [SCS_BURST_W-1:0] beat_ff;
  logic [SCS_BURST_W-1:0] nxt_seed;
  logic [SCS_BURST_W-1:0] nxt_beat;

  // wraps inside the four-beat group since only two bits exist
  always_comb begin
    nxt_seed  = seed_ff;
    nxt_beat  = beat_ff;
    burst_low = seed_ff;
    if (load) begin
      nxt_seed  = seed;
      nxt_beat  = SCS_BURST_RST;
      burst_low = seed;
    end else if (advance) begin
      nxt_beat  = SCS_BURST_W'(beat_ff + SCS_BEAT_STEP);
      burst_low = linear ? SCS_BURST_W'(seed_ff + nxt_beat) : (seed_ff ^ nxt_beat);
    end
  end

  // gated edges leave both fields untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      seed_ff <= SCS_BURST_RST;
      beat_ff <= SCS_BURST_RST;
    end else begin
      seed_ff <= nxt_seed;
      beat_ff <= nxt_beat;
    end
  end

endmodule

/* File: rtl/scs_sram_front.sv */
// pipelined sram core behind the synchronous control inputs
// assumes: controller shares MCLK; OUTPUT_ENABLE_N and the burst strap come from pins
`timescale 1ns/1ps

// Functional notes
// - all synchronous inputs are captured on rising edges with the clock gate low.
// - a high clock gate freezes the beat, burst counter, array and read data for that edge; the pin filter keeps sampling.
// - address inputs are sampled on the edge to pick one storage word.
// - the two low address bits seed the two-bit burst counter.
// - a lane is written only with its strobe low and write enable low.
// - write enable counts only on edges where the clock gate is low.
// - advance high with gate low steps the burst counter instead of loading.
// - advance low loads a fresh address and starts a new access.
// - a gated cycle does not deselect; it stretches the previous cycle.
// - selection needs select one low, select two high, select three low.
// - strap low gives linear burst order, high or open gives interleaved.
// - read data shown belongs to the address captured at the previous qualified edge.
module scs_sram_front
  import scs_pkg::*;
#(
  parameter int ADDR_W = SCS_ADDR_W,
  parameter int DEPTH  = 1 << ADDR_W
) (
  // clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    SYS_RST,
  // synchronous control
  input  wire logic                    CLOCK_GATE_N,
  input  wire logic                    ADVANCE_OR_LOAD,
  input  wire logic                    WRITE_ENABLE_N,
  input  wire logic                    CHIP_SELECT_1_N,
  input  wire logic                    CHIP_SELECT_2,
  input  wire logic                    CHIP_SELECT_3_N,
  // byte lane strobes
  input  wire logic                    BYTE_LANE_A_WRITE_N,
  input  wire logic                    BYTE_LANE_B_WRITE_N,
  input  wire logic                    BYTE_LANE_C_WRITE_N,
  input  wire logic                    BYTE_LANE_D_WRITE_N,
  // address
  input  wire logic [ADDR_W-1:2]       ADDR_UPPER,
  input  wire logic                    BURST_SEED_BIT1,
  input  wire logic                    BURST_SEED_BIT0,
  // strap and asynchronous output enable
  input  wire logic                    BURST_ORDER_MODE,
  input  wire logic                    OUTPUT_ENABLE_N,
  // data lines, lane a in the low bits, parity_lane bit on top of each lane
  input  wire logic [SCS_DATA_W-1:0]   DQ_IN,
  output logic      [SCS_DATA_W-1:0]   DQ_OUT,
  output logic                         DQ_OE_N
);

  // storage, one word per lane per location
  // the array has no reset: contents survive a reset pulse as in the real part
  logic [SCS_LANE_W-1:0] mem [DEPTH][SCS_LANES];

  // captured beat; its address field is sized by the package, so ADDR_W
  // must stay equal to SCS_ADDR_W
  scs_beat_s                beat_ff;
  scs_beat_s                nxt_beat;

  // three-flop pin filter and the settled levels
  scs_pins_s                sync1_ff;
  scs_pins_s                sync2_ff;
  scs_pins_s                sync3_ff;
  scs_pins_s                pins_ff;
  scs_pins_s                nxt_pins;

  // registered outputs
  logic [SCS_DATA_W-1:0]    dout_ff;
  logic [SCS_DATA_W-1:0]    nxt_dout;
  logic                     oe_n_ff;
  logic                     nxt_oe_n;

  // decoded controls of the current edge
  logic                     qual;
  logic                     selected;
  logic                     do_load;
  logic                     do_adv;
  logic                     do_write;
  logic [SCS_LANES-1:0]     lanes_n;
  logic [SCS_BURST_W-1:0]   burst_low;

  // pick one lane: new data where the lane is enabled, old data otherwise
  function automatic logic [SCS_LANE_W-1:0] lane_pick(
    input logic [SCS_LANE_W-1:0] old_v,
    input logic [SCS_LANE_W-1:0] new_v,
    input logic                  en
  );
    lane_pick = en ? new_v : old_v;
  endfunction

  // one lane out of a data word; lane a sits in the low bits
  function automatic logic [SCS_LANE_W-1:0] lane_of(
    input logic [SCS_DATA_W-1:0] word,
    input int                    idx
  );
    lane_of = word[idx*SCS_LANE_W +: SCS_LANE_W];
  endfunction

  // pin filter step: a new level is taken only once stages two and three agree,
  // so a one-cycle glitch on a strap or enable pin never reaches the logic
  function automatic logic settle(
    input logic held,
    input logic stage2,
    input logic stage3
  );
    settle = (stage2 == stage3) ? stage3 : held;
  endfunction

  // operation started by a load: a deselect wins over the write enable
  function automatic scs_op_e load_op(
    input logic sel,
    input logic we_n
  );
    if (!sel) begin
      load_op = SCS_OP_IDLE;
    end else if (!we_n) begin
      load_op = SCS_OP_WRITE;
    end else begin
      load_op = SCS_OP_READ;
    end
  endfunction

  // edge qualification and decode of the sampled pins
  assign qual     = ~CLOCK_GATE_N;
  assign selected = ~CHIP_SELECT_1_N & CHIP_SELECT_2 & ~CHIP_SELECT_3_N;
  assign do_load  = qual & ~ADVANCE_OR_LOAD;
  assign do_adv   = qual & ADVANCE_OR_LOAD;
  assign lanes_n  = {BYTE_LANE_D_WRITE_N, BYTE_LANE_C_WRITE_N,
                     BYTE_LANE_B_WRITE_N, BYTE_LANE_A_WRITE_N};
  // data phase of a write lands on the qualified edge after its address
  assign do_write = qual & (beat_ff.op == SCS_OP_WRITE);

  scs_burst_ctr u_burst (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .load      (do_load),
    .advance   (do_adv),
    .linear    (pins_ff.burst_mode == SCS_MODE_LINEAR),
    .seed      ({BURST_SEED_BIT1, BURST_SEED_BIT0}),
    .burst_low (burst_low)
  );

  // strap and output enable filter: a change counts once stages two and three agree
  always_comb begin
    nxt_pins.out_en_n   = settle(pins_ff.out_en_n, sync2_ff.out_en_n, sync3_ff.out_en_n);
    nxt_pins.burst_mode = settle(pins_ff.burst_mode, sync2_ff.burst_mode,
                                 sync3_ff.burst_mode);
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sync1_ff <= '{out_en_n: SCS_OE_N_RST, burst_mode: SCS_MODE_RST};
      sync2_ff <= '{out_en_n: SCS_OE_N_RST, burst_mode: SCS_MODE_RST};
      sync3_ff <= '{out_en_n: SCS_OE_N_RST, burst_mode: SCS_MODE_RST};
      pins_ff  <= '{out_en_n: SCS_OE_N_RST, burst_mode: SCS_MODE_RST};
    end else begin
      sync1_ff <= '{out_en_n: OUTPUT_ENABLE_N, burst_mode: BURST_ORDER_MODE};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pins_ff  <= nxt_pins;
    end
  end

  // beat capture: load takes new pins, advance keeps the burst going,
  // a gated edge keeps the beat as is so the access just stretches
  always_comb begin
    nxt_beat = beat_ff;
    if (do_load) begin
      nxt_beat.addr   = {ADDR_UPPER, BURST_SEED_BIT1, BURST_SEED_BIT0};
      nxt_beat.lane_n = lanes_n;
      nxt_beat.op     = load_op(selected, WRITE_ENABLE_N);
    end else if (do_adv) begin
      // upper bits held, only the burst bits move
      nxt_beat.addr   = {beat_ff.addr[ADDR_W-1:SCS_BURST_W], burst_low};
      nxt_beat.lane_n = lanes_n;
    end
  end

  // read data for the beat just captured, forwarding a write to the same word
  // so a read right behind a write never returns stale lanes
  always_comb begin
    nxt_dout = dout_ff;
    nxt_oe_n = SCS_DRIVE_OFF_N;
    if (qual && nxt_beat.op == SCS_OP_READ) begin
      for (int l = 0; l < SCS_LANES; l++) begin
        nxt_dout[l*SCS_LANE_W +: SCS_LANE_W] = lane_pick(
          mem[nxt_beat.addr][l],
          lane_of(DQ_IN, l),
          do_write && !beat_ff.lane_n[l] && beat_ff.addr == nxt_beat.addr);
      end
    end
    // drivers stay off during write data, deselect and while the pin enable is high
    if (nxt_beat.op == SCS_OP_READ && !nxt_pins.out_en_n) begin
      nxt_oe_n = ~SCS_DRIVE_OFF_N;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      beat_ff <= '{op: SCS_OP_IDLE, addr: '0, lane_n: SCS_LANES_OFF};
      dout_ff <= '0;
      oe_n_ff <= SCS_DRIVE_OFF_N;
    end else begin
      beat_ff <= nxt_beat;
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
    end
  end

  // lane writes: only enabled lanes of a write beat, only on ungated edges;
  // a gated edge holds the data phase open, so the controller must keep the
  // write data standing until the next ungated edge
  always_ff @(posedge MCLK) begin
    for (int l = 0; l < SCS_LANES; l++) begin
      if (do_write && !beat_ff.lane_n[l]) begin
        mem[beat_ff.addr][l] <= lane_of(DQ_IN, l);
      end
    end
  end

  assign DQ_OUT  = dout_ff;
  assign DQ_OE_N = oe_n_ff;

endmodule

/* File: verification/scs_ctl_model.sv */
// controller model: drives control pins and write data of the sram front
// assumes: shares the bench clock; every change lands 1 ns after a rise
`timescale 1ns/1ps
module scs_ctl_model
  import scs_pkg::*;
(
  // clock
  input  wire logic                  clk,
  // control and data towards the device
  output logic                       gate_n,
  output logic                       adv,
  output logic                       we_n,
  output logic [2:0]                 cs,
  output logic [SCS_LANES-1:0]       lane_n,
  output logic [SCS_ADDR_W-1:0]      addr,
  output logic [SCS_DATA_W-1:0]      din
);
  // deselected and gated until the first beat
  initial begin
    {gate_n, adv, we_n, cs, lane_n, addr, din} = {3'h5, 3'h5, SCS_LANES_OFF, 44'h0};
  end

  // one beat per call; loads follow deselects unless a caller breaks it
  task automatic beat(input logic g, a, input logic [2:0] c, input scs_beat_s b,
                      input logic [SCS_DATA_W-1:0] d, input logic dv);
    @(posedge clk);
    #1;
    {gate_n, adv, cs, lane_n, addr} = {g, a, c, b.lane_n, b.addr};
    we_n = (b.op != SCS_OP_WRITE);
    din = dv ? d : ~din; // released lines toggle so stale data never matches
  endtask
endmodule

/* File: verification/scs_front_chk.sv */
// checker for the sram front: control-to-output relations at the pins
// assumes: bound into scs_sram_front, single clock domain
`timescale 1ns/1ps
module scs_front_chk
  import scs_pkg::*;
(
  // clock and reset
  input wire logic                  MCLK,
  input wire logic                  SYS_RST,
  // control at the pins
  input wire logic                  CLOCK_GATE_N,
  input wire logic                  ADVANCE_OR_LOAD,
  input wire logic                  WRITE_ENABLE_N,
  input wire logic                  CHIP_SELECT_1_N,
  input wire logic                  CHIP_SELECT_2,
  input wire logic                  CHIP_SELECT_3_N,
  input wire logic                  OUTPUT_ENABLE_N,
  // data side
  input wire logic [SCS_DATA_W-1:0] DQ_OUT,
  input wire logic                  DQ_OE_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // qualified load and selection
  wire logic sel = !CHIP_SELECT_1_N && CHIP_SELECT_2 && !CHIP_SELECT_3_N;
  wire logic ld  = !CLOCK_GATE_N && !ADVANCE_OR_LOAD;
  // six samples cover the pin filter latency with margin
  sequence s_oe_on;   !OUTPUT_ENABLE_N [*6]; endsequence
  sequence s_idle_ld; ld && !sel; endsequence
  property p_gate_hold; CLOCK_GATE_N |=> $stable(DQ_OUT); endproperty
  property p_rst_out; $fell(SYS_RST) |-> DQ_OE_N && DQ_OUT == '0; endproperty
  property p_desel; s_idle_ld |=> DQ_OE_N; endproperty
  property p_write_off; ld && sel && !WRITE_ENABLE_N |=> DQ_OE_N; endproperty
  property p_read_on; s_oe_on ##0 (ld && sel && WRITE_ENABLE_N) |=> !DQ_OE_N; endproperty
  property p_idle_adv;
    s_idle_ld ##1 (!CLOCK_GATE_N && ADVANCE_OR_LOAD) |=> DQ_OE_N;
  endproperty
  property p_gate_keep; s_oe_on ##0 (CLOCK_GATE_N && !DQ_OE_N) |=> !DQ_OE_N; endproperty
  property p_oe_pin; OUTPUT_ENABLE_N [*6] |=> DQ_OE_N; endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("output moved on gated edge");
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  a_desel: assert property (p_desel) else $error("deselected load drives data");
  a_write_off: assert property (p_write_off) else $error("write beat drives data");
  a_read_on: assert property (p_read_on) else $error("read beat not driving");
  a_idle_adv: assert property (p_idle_adv) else $error("advance left idle");
  a_gate_keep: assert property (p_gate_keep) else $error("gate deselected");
  a_oe_pin: assert property (p_oe_pin) else $error("drives with pin high");
endmodule

bind scs_sram_front scs_front_chk chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .CLOCK_GATE_N(CLOCK_GATE_N), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
  .WRITE_ENABLE_N(WRITE_ENABLE_N), .CHIP_SELECT_1_N(CHIP_SELECT_1_N),
  .CHIP_SELECT_2(CHIP_SELECT_2), .CHIP_SELECT_3_N(CHIP_SELECT_3_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N));

/* File: verification/tb_top.sv */
// bench for the sram front: scenario tasks drive the controller model
// assumes: expected words kept locally, written data rides one beat later
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import scs_pkg::*;
;
  logic                  MCLK = 1'h0, SYS_RST = 1'h1, oe_n = 1'h0, mode = 1'h1;
  logic                  gate_n, adv, we_n, oe_out_n, pend_v = 1'h0;
  logic [2:0]            cs;
  logic [SCS_LANES-1:0]  lane_n;
  logic [SCS_ADDR_W-1:0] addr;
  logic [SCS_DATA_W-1:0] din, dout, pend = '0;
  logic [SCS_ADDR_W-1:0] pend_a = '0;
  logic [SCS_LANES-1:0]  pend_l = '1;
  logic [SCS_DATA_W-1:0] mem [256];
  int                    num_errors = 0, n_tests = 0;
  always #2 MCLK = ~MCLK;

  scs_ctl_model ctl_u (.clk(MCLK), .gate_n(gate_n), .adv(adv), .we_n(we_n), .cs(cs),
    .lane_n(lane_n), .addr(addr), .din(din));
  scs_sram_front dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLOCK_GATE_N(gate_n),
    .ADVANCE_OR_LOAD(adv), .WRITE_ENABLE_N(we_n), .CHIP_SELECT_1_N(cs[2]),
    .CHIP_SELECT_2(cs[1]), .CHIP_SELECT_3_N(cs[0]), .BYTE_LANE_A_WRITE_N(lane_n[0]),
    .BYTE_LANE_B_WRITE_N(lane_n[1]), .BYTE_LANE_C_WRITE_N(lane_n[2]),
    .BYTE_LANE_D_WRITE_N(lane_n[3]), .ADDR_UPPER(addr[7:2]), .BURST_SEED_BIT1(addr[1]),
    .BURST_SEED_BIT0(addr[0]), .BURST_ORDER_MODE(mode), .OUTPUT_ENABLE_N(oe_n),
    .DQ_IN(din), .DQ_OUT(dout), .DQ_OE_N(oe_out_n));

  // one beat; write data rides on the next ungated beat, which is also when the
  // expected words take it, lane by lane, as the array does
  task automatic bt(input logic g, a, input logic [2:0] c, input scs_op_e op,
    input logic [SCS_ADDR_W-1:0] ad, input logic [SCS_LANES-1:0] ln,
    input logic [SCS_DATA_W-1:0] d);
    if (!g && pend_v)
      for (int k = 0; k < SCS_LANES; k++)
        if (!pend_l[k])
          mem[pend_a][k*SCS_LANE_W +: SCS_LANE_W] = pend[k*SCS_LANE_W +: SCS_LANE_W];
    ctl_u.beat(g, a, c, '{op, ad, ln}, pend, pend_v);
    if (!g) begin
      pend_v = !a && c == 3'h2 && op == SCS_OP_WRITE;
      pend   = d;
      pend_a = ad;
      pend_l = ln;
    end
  endtask

  // back-to-back writes, forwarded read, partial lane write
  task t_write_read;
    bt(0, 0, 3'h2, SCS_OP_WRITE, 8'h14, 4'h0, 36'h123456789);
    bt(0, 0, 3'h2, SCS_OP_WRITE, 8'h15, 4'h0, 36'hFEDCBA987);
    bt(0, 0, 3'h2, SCS_OP_READ, 8'h15, 4'hF, '0);
    bt(0, 0, 3'h2, SCS_OP_READ, 8'h14, 4'hF, '0);
    `CHK(dout, mem[8'h15])
    bt(0, 0, 3'h2, SCS_OP_WRITE, 8'h14, 4'h5, 36'hABCDE0123);
    `CHK(dout, mem[8'h14])
    bt(0, 0, 3'h2, SCS_OP_READ, 8'h14, 4'hF, '0);
    bt(0, 0, 3'h5, SCS_OP_IDLE, 8'h00, 4'hF, '0);
    `CHK(dout, mem[8'h14])
  endtask

  // four-beat burst from seed s with one gated edge in the middle
  task t_burst(input logic m, input logic [1:0] s);
    logic [1:0] lo;
    mode = m;
    for (int k = 0; k < 4; k++)
      bt(0, 0, 3'h2, SCS_OP_WRITE, 8'h20 + 8'(k), 4'h0, {4{9'h1A5 + 9'(k) + 9'(m)}});
    repeat (2) bt(0, 0, 3'h5, SCS_OP_IDLE, 8'h00, 4'hF, '0);
    bt(0, 0, 3'h2, SCS_OP_READ, {6'h08, s}, 4'hF, '0);
    for (int n = 0; n < 5; n++) begin
      bt(n == 2, 1, 3'h2, SCS_OP_READ, 8'h00, 4'hF, '0);
      lo = m ? s ^ 2'(n - (n > 2)) : s + 2'(n - (n > 2));
      `CHK(dout, mem[{6'h08, lo}])
    end
  endtask

  // select combinations, advance after idle, output enable pin
  task t_select;
    for (int c = 0; c < 8; c++) begin
      bt(0, 0, 3'(c), SCS_OP_READ, 8'h14, 4'hF, '0);
      bt(0, 1, 3'h2, SCS_OP_READ, 8'h00, 4'hF, '0);
      `CHK(oe_out_n, 1'(c != 2))
      bt(0, 0, 3'h5, SCS_OP_IDLE, 8'h00, 4'hF, '0);
      `CHK(oe_out_n, 1'(c != 2))
    end
    oe_n = 1'h1;
    repeat (7) bt(0, 0, 3'h2, SCS_OP_READ, 8'h14, 4'hF, '0);
    `CHK(oe_out_n, 1'h1)
    oe_n = 1'h0;
    repeat (7) bt(0, 0, 3'h2, SCS_OP_READ, 8'h14, 4'hF, '0);
  endtask

  task close_out;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the fewer than a hundred cycles the scenarios take
  initial begin
    #20000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge MCLK);
    #1 SYS_RST = 1'h0;
    repeat (6) bt(0, 0, 3'h5, SCS_OP_IDLE, 8'h00, 4'hF, '0);
    t_write_read();
    t_burst(1'h1, 2'h1);
    t_burst(1'h0, 2'h1);
    t_select();
    close_out();
  end
endmodule
